//--- epw_enc_model.sv
// Purpose: Two-phase encoder model driving one channel's phase pins
// Assumes: Levels change on the falling clock edge only
// Notes:   Each level pair dwells three cycles so the design sees it settle
`default_nettype none
module epw_enc_model (
  input  wire logic clk,
  output var logic  pha,
  output var logic  phb
);
  timeunit 1ns;
  timeprecision 1ps;
  // Rest at 00 so reset-time samples agree with the pins
  initial begin
    pha = 1'b0;
    phb = 1'b0;
  end
  // One step of the shaft: new level pair, then dwell
  task automatic put(input logic [1:0] ab);
    @(negedge clk);
    {pha, phb} = ab;
    repeat (2) @(negedge clk);
  endtask
endmodule
`default_nettype wire

//--- epw_pkg.sv
// Purpose: Shared constants for the encoder counter and sync PWM block
// Assumes: One clock, synchronous active-low reset
// Notes:   Mode codes select the encoder counting rule per channel
`default_nettype none
package epw_pkg;
  localparam int CNT_W = 16;               // Counter width
  localparam logic [15:0] CNT_RST = 16'h0000;  // Counter value after reset
  localparam logic [15:0] CNT_MAX = 16'hffff;  // Wrap point counting up
  typedef enum logic [2:0] {
    EPW_MODE_NORMAL = 3'b000,              // Encoder counting off
    EPW_MODE_ENC1   = 3'b001,              // Every edge, quadrature
    EPW_MODE_ENC2   = 3'b010,              // Phase A falling only
    EPW_MODE_ENC3   = 3'b011,              // A fall up, B fall down
    EPW_MODE_ENC4   = 3'b100               // Phase B edges only
  } epw_mode_t;
endpackage
`default_nettype wire

//--- epw_top.sv
// Purpose: Encoder counting on channels 1/2, period capture links to
//          channel 0, and reset-synchronized 3-phase PWM on channels 3/4
// Assumes: All inputs synchronous to ref_clk (200 MHz)
// Notes:   Control bits are plain ports; no register bus
`default_nettype none

// Behaviour
// - Mode 2: A falls, B decides direction
// - Mode 3: A fall up, B fall down
// - Mode 4: only B edges count, A gives direction
// - Ch1 uses inputs 1/2, ch2 inputs 3/4
// - Ch0 clears on compare C; A, C mark periods
// - Ch1 count clock captures ch0 B, buffered D
// - Ch0 matches A/C capture ch1 count
// - Channels 3 and 4 make three PWM pairs
// - Six pins form phases one to three
// - Negative pin toggles with positive; complement only if level selects differ
// - Up-count, clear on cycle compare match
// - Each pair has its own compare register
// - Toggle on own match and on clear
// - Encoder modes only ch1/2; clock select ignored
// - Overflow and underflow flags on wrap
// - Direction flag readable
// - Mode 1 counts every quadrature edge
module epw_top (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire logic                     ext_clock_in_1,
  input  wire logic                     ext_clock_in_2,
  input  wire logic                     ext_clock_in_3,
  input  wire logic                     ext_clock_in_4,
  input  wire epw_pkg::epw_mode_t       ch1_mode,
  input  wire epw_pkg::epw_mode_t       ch2_mode,
  input  wire logic                     ch1_int_clk_en,
  input  wire logic                     ch2_int_clk_en,
  input  wire logic                     ch0_start,
  input  wire logic [epw_pkg::CNT_W-1:0] ch0_compare_a,
  input  wire logic [epw_pkg::CNT_W-1:0] ch0_compare_c,
  input  wire logic                     flag_clear,
  input  wire logic                     sync_pwm_mode,
  input  wire logic                     pwm_start,
  input  wire logic                     pos_output_level_sel,
  input  wire logic                     neg_output_level_sel,
  input  wire logic [epw_pkg::CNT_W-1:0] ch3_cycle_compare,
  input  wire logic [epw_pkg::CNT_W-1:0] phase1_compare,
  input  wire logic [epw_pkg::CNT_W-1:0] phase2_compare,
  input  wire logic [epw_pkg::CNT_W-1:0] phase3_compare,
  output logic      [epw_pkg::CNT_W-1:0] ch0_count,
  output logic      [epw_pkg::CNT_W-1:0] ch1_count,
  output logic      [epw_pkg::CNT_W-1:0] ch2_count,
  output logic      [epw_pkg::CNT_W-1:0] ch0_capture_b,
  output logic      [epw_pkg::CNT_W-1:0] ch0_buffer_d,
  output logic      [epw_pkg::CNT_W-1:0] ch1_capture_a,
  output logic      [epw_pkg::CNT_W-1:0] ch1_capture_b,
  output logic      [1:0]               overflow_flag,
  output logic      [1:0]               underflow_flag,
  output logic      [1:0]               count_direction_flag,
  output logic      [epw_pkg::CNT_W-1:0] ch3_count,
  output logic      [epw_pkg::CNT_W-1:0] ch4_count,
  output logic                          pwm_phase1_pos,
  output logic                          pwm_phase1_neg,
  output logic                          pwm_phase2_pos,
  output logic                          pwm_phase2_neg,
  output logic                          pwm_phase3_pos,
  output logic                          pwm_phase3_neg
);
  import epw_pkg::*;

  // Decode one count step: {up, down} from levels and edges
  function automatic logic [1:0] enc_step(
    input epw_mode_t m,
    input logic      a, b, a_p, b_p
  );
    logic ar, af, br, bf;  // Edges of both phases
    logic up, dn;          // Step direction before the tie check
    ar = a & ~a_p;
    af = ~a & a_p;
    br = b & ~b_p;
    bf = ~b & b_p;
    up = 1'b0;
    dn = 1'b0;
    case (m)
      EPW_MODE_ENC1: begin
        // Quadrature, A leading B counts up
        up = (br & a) | (bf & ~a) | (ar & ~b) | (af & b);
        dn = (br & ~a) | (bf & a) | (ar & b) | (af & ~b);
      end
      EPW_MODE_ENC2: begin
        up = af & b;
        dn = af & ~b;
      end
      EPW_MODE_ENC3: begin
        up = af & b;
        dn = bf & a;
      end
      EPW_MODE_ENC4: begin
        up = (br & a) | (bf & ~a);
        dn = (bf & a) | (br & ~a);
      end
      default: up = 1'b0;
    endcase
    // Up and down at once is ambiguous; drop the step
    enc_step = (up & dn) ? 2'b00 : {up, dn};
  endfunction

  logic [3:0] pin_r;        // Sampled encoder pins
  logic [3:0] pin_prev_r;   // Previous sample for edge detect
  logic [1:0] st1, st2;     // Ch1/ch2 up/down step
  logic       tick1, tick2; // Ch1/ch2 counting clock events
  logic       enc1, enc2;   // Channel in an encoder mode
  logic       c0_match_a, c0_match_c; // Ch0 period A and C matches
  logic       c3_clear, pwm_run;      // Carrier end; PWM pair counting

  // Sample pins each clock; edges come from two samples
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_r      <= 4'h0;
      pin_prev_r <= 4'h0;
    end else begin
      pin_r      <= {ext_clock_in_4, ext_clock_in_3,
                     ext_clock_in_2, ext_clock_in_1};
      pin_prev_r <= pin_r;
    end
  end

  assign enc1 = (ch1_mode != EPW_MODE_NORMAL);
  assign enc2 = (ch2_mode != EPW_MODE_NORMAL);
  // Ch1 on inputs 1/2, ch2 on inputs 3/4
  assign st1 = enc_step(ch1_mode, pin_r[0], pin_r[1],
                        pin_prev_r[0], pin_prev_r[1]);
  assign st2 = enc_step(ch2_mode, pin_r[2], pin_r[3],
                        pin_prev_r[2], pin_prev_r[3]);
  // Internal clock select only counts outside encoder modes
  assign tick1 = enc1 ? (st1 != 2'b00) : ch1_int_clk_en;
  assign tick2 = enc2 ? (st2 != 2'b00) : ch2_int_clk_en;

  // Channel 0: free counter cleared on compare C
  assign c0_match_a = ch0_start && (ch0_count == ch0_compare_a);
  assign c0_match_c = ch0_start && (ch0_count == ch0_compare_c);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ch0_count <= CNT_RST;
    end else if (c0_match_c) begin
      ch0_count <= CNT_RST;
    end else if (ch0_start) begin
      ch0_count <= ch0_count + 16'h0001;
    end
  end

  // Ch1 count clock captures ch0 count; old B moves to D
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ch0_capture_b <= CNT_RST;
      ch0_buffer_d  <= CNT_RST;
    end else if (tick1) begin
      ch0_capture_b <= ch0_count;
      ch0_buffer_d  <= ch0_capture_b;
    end
  end

  // Period captures of ch1 position at ch0 A/C matches
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ch1_capture_a <= CNT_RST;
      ch1_capture_b <= CNT_RST;
    end else begin
      if (c0_match_a) begin
        ch1_capture_a <= ch1_count;
      end
      if (c0_match_c) begin
        ch1_capture_b <= ch1_count;
      end
    end
  end

  // Ch1 up/down counter with wrap flags
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ch1_count               <= CNT_RST;
      overflow_flag[0]        <= 1'b0;
      underflow_flag[0]       <= 1'b0;
      count_direction_flag[0] <= 1'b1;
    end else begin
      if (tick1) begin
        if (enc1 && st1[0]) begin
          ch1_count <= ch1_count - 16'h0001;
        end else begin
          ch1_count <= ch1_count + 16'h0001;
        end
      end
      if (enc1 && st1 != 2'b00) begin
        count_direction_flag[0] <= st1[1];
      end
      // Set beats a clear in the same cycle
      if (tick1 && !(enc1 && st1[0]) && ch1_count == CNT_MAX) begin
        overflow_flag[0] <= 1'b1;
      end else if (flag_clear) begin
        overflow_flag[0] <= 1'b0;
      end
      if (tick1 && enc1 && st1[0] && ch1_count == CNT_RST) begin
        underflow_flag[0] <= 1'b1;
      end else if (flag_clear) begin
        underflow_flag[0] <= 1'b0;
      end
    end
  end

  // Ch2 up/down counter with wrap flags
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ch2_count               <= CNT_RST;
      overflow_flag[1]        <= 1'b0;
      underflow_flag[1]       <= 1'b0;
      count_direction_flag[1] <= 1'b1;
    end else begin
      if (tick2) begin
        if (enc2 && st2[0]) begin
          ch2_count <= ch2_count - 16'h0001;
        end else begin
          ch2_count <= ch2_count + 16'h0001;
        end
      end
      if (enc2 && st2 != 2'b00) begin
        count_direction_flag[1] <= st2[1];
      end
      if (tick2 && !(enc2 && st2[0]) && ch2_count == CNT_MAX) begin
        overflow_flag[1] <= 1'b1;
      end else if (flag_clear) begin
        overflow_flag[1] <= 1'b0;
      end
      if (tick2 && enc2 && st2[0] && ch2_count == CNT_RST) begin
        underflow_flag[1] <= 1'b1;
      end else if (flag_clear) begin
        underflow_flag[1] <= 1'b0;
      end
    end
  end

  // Reset-synchronized PWM: ch3/ch4 counters in lockstep
  assign pwm_run  = sync_pwm_mode && pwm_start;
  assign c3_clear = pwm_run && (ch3_count == ch3_cycle_compare);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ch3_count <= CNT_RST;
      ch4_count <= CNT_RST;
    end else if (c3_clear) begin
      ch3_count <= CNT_RST;
      ch4_count <= CNT_RST;
    end else if (pwm_run) begin
      ch3_count <= ch3_count + 16'h0001;
      ch4_count <= ch4_count + 16'h0001;
    end
  end

  // Outputs: preset from level select while stopped, toggle when running.
  // Pairs toggle together, so transitions are shared exactly.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwm_phase1_pos <= 1'b0;
      pwm_phase1_neg <= 1'b0;
      pwm_phase2_pos <= 1'b0;
      pwm_phase2_neg <= 1'b0;
      pwm_phase3_pos <= 1'b0;
      pwm_phase3_neg <= 1'b0;
    end else if (!pwm_run) begin
      pwm_phase1_pos <= pos_output_level_sel;
      pwm_phase2_pos <= pos_output_level_sel;
      pwm_phase3_pos <= pos_output_level_sel;
      pwm_phase1_neg <= neg_output_level_sel;
      pwm_phase2_neg <= neg_output_level_sel;
      pwm_phase3_neg <= neg_output_level_sel;
    end else begin
      // Toggle on own match or on clear; a match on the clear cycle
      // toggles once only
      if (c3_clear || ch3_count == phase1_compare) begin
        pwm_phase1_pos <= ~pwm_phase1_pos;
        pwm_phase1_neg <= ~pwm_phase1_neg;
      end
      if (c3_clear || ch4_count == phase2_compare) begin
        pwm_phase2_pos <= ~pwm_phase2_pos;
        pwm_phase2_neg <= ~pwm_phase2_neg;
      end
      if (c3_clear || ch4_count == phase3_compare) begin
        pwm_phase3_pos <= ~pwm_phase3_pos;
        pwm_phase3_neg <= ~pwm_phase3_neg;
      end
    end
  end

endmodule
`default_nettype wire

//--- epw_top_sva.sv
// Purpose: Port-level checks for the encoder counter and sync PWM
// Assumes: Encoder pins dwell at least two cycles per level
// Notes:   Encoder checks cover channel 1 only
`default_nettype none
module epw_chk import epw_pkg::*; (
  input wire logic             ref_clk,
  input wire logic             rst_n,
  input wire logic             ext_clock_in_1,
  input wire logic             ext_clock_in_2,
  input wire epw_mode_t        ch1_mode,
  input wire logic [CNT_W-1:0] ch1_count,
  input wire logic [1:0]       count_direction_flag,
  input wire logic             ch0_start,
  input wire logic [CNT_W-1:0] ch0_count,
  input wire logic [CNT_W-1:0] ch0_compare_c,
  input wire logic [CNT_W-1:0] ch1_capture_b,
  input wire logic             sync_pwm_mode,
  input wire logic             pwm_start,
  input wire logic             pos_output_level_sel,
  input wire logic             neg_output_level_sel,
  input wire logic [CNT_W-1:0] ch3_cycle_compare,
  input wire logic [CNT_W-1:0] phase1_compare,
  input wire logic [CNT_W-1:0] ch3_count,
  input wire logic [CNT_W-1:0] ch4_count,
  input wire logic             pwm_phase1_pos,
  input wire logic             pwm_phase1_neg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] live_r;    // Pin history valid after reset
  logic       pa_r, pb_r; // Previous pin samples
  logic       pa, pb, up, dn, af, bf, br, run, hit1;
  // Pin history; no reset on samples, gated by live_r instead
  always_ff @(posedge ref_clk) begin
    live_r <= rst_n ? {live_r[0], 1'b1} : 2'b00;
    pa_r   <= ext_clock_in_1;
    pb_r   <= ext_clock_in_2;
  end
  assign pa   = ext_clock_in_1;
  assign pb   = ext_clock_in_2;
  assign af   = pa_r & ~pa;
  assign bf   = pb_r & ~pb;
  assign br   = ~pb_r & pb;
  assign run  = sync_pwm_mode & pwm_start;
  assign hit1 = ch3_count == phase1_compare || ch3_count == ch3_cycle_compare;
  // Expected step; both pins moving at once counts nothing
  always_comb begin
    {up, dn} = 2'b00;
    if (live_r[1] && ((pa_r ^ pa) != (pb_r ^ pb))) begin
      case (ch1_mode)
        EPW_MODE_ENC2: {up, dn} = {af & pb, af & ~pb};
        EPW_MODE_ENC3: {up, dn} = {af & pb, bf & pa};
        EPW_MODE_ENC4: {up, dn} = {br & pa | bf & ~pa, bf & pa | br & ~pa};
        default:       {up, dn} = 2'b00;
      endcase
    end
  end
  sequence wrap_s;
    run && ch3_count == ch3_cycle_compare;
  endsequence
  sequence cleared_s;
    ch3_count == 16'h0 && ch4_count == 16'h0;
  endsequence
  // Pins are registered once more inside, so a step shows two edges on
  enc_up_a: assert property (up |-> ##2
    ch1_count == $past(ch1_count) + 16'h1 && count_direction_flag[0])
    else $error("encoder up step wrong");
  enc_down_a: assert property (dn |-> ##2
    ch1_count == $past(ch1_count) - 16'h1 && !count_direction_flag[0])
    else $error("encoder down step wrong");
  enc_idle_a: assert property (!up && !dn
    && live_r[1] && ch1_mode inside {EPW_MODE_ENC2, EPW_MODE_ENC3,
    EPW_MODE_ENC4} |-> ##2 $stable(ch1_count))
    else $error("encoder counted an ignored edge");
  ch0_clear_a: assert property (ch0_start
    && ch0_count == ch0_compare_c |=> ch0_count == 16'h0
    && ch1_capture_b == $past(ch1_count))
    else $error("channel 0 clear or capture wrong");
  pwm_hold_a: assert property (!run |=> $stable(ch3_count)
    && $stable(ch4_count) && pwm_phase1_pos == $past(pos_output_level_sel)
    && pwm_phase1_neg == $past(neg_output_level_sel))
    else $error("stopped pwm not static");
  pwm_clear_a: assert property (wrap_s |=> cleared_s)
    else $error("pwm counters not cleared");
  pwm_count_a: assert property (run
    && ch3_count != ch3_cycle_compare |=> ch3_count == $past(ch3_count)
    + 16'h1 && ch4_count == $past(ch4_count) + 16'h1)
    else $error("pwm counters not counting up");
  pwm_toggle_a: assert property (run |=>
    (pwm_phase1_pos != $past(pwm_phase1_pos)) == $past(hit1))
    else $error("phase one toggle wrong");
  pwm_pair_a: assert property (run |=>
    (pwm_phase1_pos ^ pwm_phase1_neg)
    == $past(pwm_phase1_pos ^ pwm_phase1_neg)) else $error("pair split");
endmodule
bind epw_top epw_chk i_chk (.ref_clk, .rst_n, .ext_clock_in_1, .ext_clock_in_2,
  .ch1_mode, .ch1_count, .count_direction_flag, .ch0_start, .ch0_count,
  .ch0_compare_c, .ch1_capture_b, .sync_pwm_mode, .pwm_start,
  .pos_output_level_sel, .neg_output_level_sel, .ch3_cycle_compare,
  .phase1_compare, .ch3_count, .ch4_count, .pwm_phase1_pos, .pwm_phase1_neg);
`default_nettype wire

//--- epw_top_tb_top.sv
// Purpose: Self-checking bench for the encoder counter and sync PWM
// Assumes: 200 MHz ref_clk; inputs move on the falling edge
// Notes:   Encoder pins come from two partner models
`default_nettype none
`define CHK(act, exp) begin n_tests++; if ((act) !== (exp)) begin \
  miscompares++; $display("mismatch at %0t got %h exp %h", $time, act, \
  exp); end end
module epw_top_tb_top import epw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        ext_clock_in_1, ext_clock_in_2, ext_clock_in_3, ext_clock_in_4;
  epw_mode_t   ch1_mode, ch2_mode;
  logic        ch1_int_clk_en, ch2_int_clk_en, ch0_start, flag_clear;
  logic        sync_pwm_mode, pwm_start;
  logic        pos_output_level_sel, neg_output_level_sel;
  logic [15:0] ch0_compare_a, ch0_compare_c, ch3_cycle_compare;
  logic [15:0] phase1_compare, phase2_compare, phase3_compare;
  logic [15:0] ch0_count, ch1_count, ch2_count, ch0_capture_b, ch0_buffer_d;
  logic [15:0] ch1_capture_a, ch1_capture_b, ch3_count, ch4_count;
  logic [1:0]  overflow_flag, underflow_flag, count_direction_flag;
  logic        pwm_phase1_pos, pwm_phase1_neg, pwm_phase2_pos;
  logic        pwm_phase2_neg, pwm_phase3_pos, pwm_phase3_neg;
  int          miscompares = 0;
  int          n_tests = 0;
  logic [1:0]  fwd [4] = '{2'b10, 2'b11, 2'b01, 2'b00};  // A leads B
  logic [1:0]  bwd [4] = '{2'b01, 2'b11, 2'b10, 2'b00};  // B leads A
  logic [15:0] gain [5] = '{16'h0, 16'h4, 16'h1, 16'h1, 16'h2};  // Per cycle
  epw_enc_model i_enc1 (.clk(ref_clk), .pha(ext_clock_in_1),
                        .phb(ext_clock_in_2));
  epw_enc_model i_enc2 (.clk(ref_clk), .pha(ext_clock_in_3),
                        .phb(ext_clock_in_4));
  epw_top i_dut (.*);
  always #2.5 ref_clk = ~ref_clk;
  // One full encoder cycle on either channel
  task automatic quad(input bit ch2, input bit back);
    for (int i = 0; i < 4; i++) begin
      if (ch2) i_enc2.put(back ? bwd[i] : fwd[i]);
      else i_enc1.put(back ? bwd[i] : fwd[i]);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Tests need well under 1000 cycles; 50 us is ten times that
  initial begin
    #50us;
    miscompares++;
    print_verdict();
  end
  initial begin
    {ch1_int_clk_en, ch2_int_clk_en, ch0_start, flag_clear} = 4'h0;
    {sync_pwm_mode, pwm_start} = 2'b00;
    {pos_output_level_sel, neg_output_level_sel} = 2'b01;
    {ch0_compare_a, ch0_compare_c, ch3_cycle_compare} = '0;
    {phase1_compare, phase2_compare, phase3_compare} = '0;
    ch1_mode = EPW_MODE_NORMAL;
    ch2_mode = EPW_MODE_NORMAL;
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    `CHK({ch1_count, count_direction_flag}, 18'h3)
    `CHK({pwm_phase1_pos, pwm_phase1_neg, pwm_phase3_neg}, 3'b011)
    $display("test reset done");
    // Backward then forward in modes 1 to 4; mode 1 wraps both ways
    for (int m = 1; m < 5; m++) begin
      ch1_mode = epw_mode_t'(m);
      quad(1'b0, 1'b1);
      `CHK(ch1_count, 16'h0 - gain[m])
      `CHK(count_direction_flag[0], 1'b0)
      quad(1'b0, 1'b0);
      `CHK(ch1_count, 16'h0)
    end
    `CHK({overflow_flag[0], underflow_flag[0]}, 2'b11)
    flag_clear = 1'b1;
    @(negedge ref_clk);
    flag_clear = 1'b0;
    @(negedge ref_clk);
    `CHK({overflow_flag, underflow_flag}, 4'h0)
    ch2_mode = EPW_MODE_ENC4;
    quad(1'b1, 1'b0);
    `CHK({ch2_count, ch1_count}, 32'h0002_0000)
    `CHK(count_direction_flag, 2'b11)
    // Internal enable is ignored in encoder mode, counts in normal mode
    ch2_int_clk_en = 1'b1;
    repeat (2) @(negedge ref_clk);
    `CHK(ch2_count, 16'h0002)
    ch2_mode = EPW_MODE_NORMAL;
    repeat (2) @(negedge ref_clk);
    ch2_int_clk_en = 1'b0;
    `CHK(ch2_count, 16'h0004)
    $display("test encoder done");
    // Channel 0 stops at 4; one down step captures it
    {pos_output_level_sel, neg_output_level_sel} = 2'b10;
    {ch0_compare_a, ch0_compare_c} = {16'h0003, 16'h0009};
    ch0_start = 1'b1;
    repeat (4) @(negedge ref_clk);
    ch0_start = 1'b0;
    i_enc1.put(2'b01);
    `CHK(ch1_count, 16'hffff)
    `CHK({ch0_capture_b, ch0_buffer_d}, 32'h0004_0000)
    ch0_start = 1'b1;
    repeat (12) @(negedge ref_clk);
    ch0_start = 1'b0;
    `CHK(ch0_count, 16'h0006)
    `CHK({ch1_capture_a, ch1_capture_b}, 32'hffff_ffff)
    $display("test capture done");
    {ch3_cycle_compare, phase1_compare} = {16'h0009, 16'h0002};
    {phase2_compare, phase3_compare} = {16'h0005, 16'h0009};
    // Counters must stand at zero before the mode is entered
    `CHK({ch3_count, ch4_count}, 32'h0)
    sync_pwm_mode = 1'b1;
    pwm_start = 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK({ch3_count, ch4_count}, 32'h0003_0003)
    `CHK({pwm_phase1_pos, pwm_phase1_neg}, 2'b01)
    `CHK(pwm_phase2_pos, 1'b1)
    repeat (12) @(negedge ref_clk);
    `CHK(ch3_count, 16'h0005)
    `CHK({pwm_phase1_pos, pwm_phase2_pos}, 2'b01)
    `CHK({pwm_phase3_pos, pwm_phase3_neg}, 2'b01)
    pwm_start = 1'b0;
    repeat (2) @(negedge ref_clk);
    `CHK({ch4_count, pwm_phase2_pos, pwm_phase2_neg}, 18'h16)
    $display("test pwm done");
    print_verdict();
  end
endmodule
`default_nettype wire
